// >>> ifsb_cfg.svh
// Offsets, field positions, masks and reset values of the flag bank.
`ifndef IFSB_CFG_SVH
`define IFSB_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define IFSB_DW        16
`define IFSB_NW        4
`define IFSB_PAW       12
`define IFSB_PDW       32

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IFSB_OFF_FLAG0 12'h000
`define IFSB_OFF_FLAG1 12'h004
`define IFSB_OFF_FLAG2 12'h008
`define IFSB_OFF_FLAG3 12'h00c
`define IFSB_OFF_ENA0  12'h010
`define IFSB_OFF_ENA1  12'h014
`define IFSB_OFF_ENA2  12'h018
`define IFSB_OFF_ENA3  12'h01c
`define IFSB_OFF_EVT   12'h020
`define IFSB_OFF_EMSK  12'h024

// ----------------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------------
`define IFSB_IMPL0     16'hb9ef
`define IFSB_IMPL1     16'hf85f
`define IFSB_IMPL2     16'h0200
`define IFSB_IMPL3     16'h4006
`define IFSB_FLAG_RST  16'h0000
`define IFSB_ZERO16    16'h0000
`define IFSB_EVT_BIT   0

// ----------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------
`define IFSB_B0_MEMOP  15
`define IFSB_B0_ADC    13
`define IFSB_B0_S1TX   12
`define IFSB_B0_S1RX   11
`define IFSB_B0_CC2T   8
`define IFSB_B0_CC1T   7
`define IFSB_B0_CC4E   6
`define IFSB_B0_CC3E   5
`define IFSB_B0_TMR1   3
`define IFSB_B0_CC2E   2
`define IFSB_B0_CC1E   1
`define IFSB_B0_EXT0   0
`define IFSB_B1_S2TX   15
`define IFSB_B1_S2RX   14
`define IFSB_B1_EXT2   13
`define IFSB_B1_CC4T   12
`define IFSB_B1_CC3T   11
`define IFSB_B1_CC5E   6
`define IFSB_B1_EXT1   4
`define IFSB_B1_PCHG   3
`define IFSB_B1_CMP    2
`define IFSB_B1_P1BC   1
`define IFSB_B1_P1EV   0
`define IFSB_B2_CC5T   9
`define IFSB_B3_CAL    14
`define IFSB_B3_P2BC   2
`define IFSB_B3_P2EV   1

`endif

// >>> ifsb_flag_word.sv
// One flag status word: hardware set, software write, set wins.
`timescale 1ns/1ps
`default_nettype none

module ifsb_flag_word
  import ifsb_pkg::*;
#(
  parameter ifsb_word_type IMPL = `IFSB_ZERO16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          pce,
  input  wire ifsb_word_type hw_set,
  input  wire logic          wr_en,
  input  wire ifsb_word_type wr_data,
  output var  ifsb_word_type flags
);

  ifsb_word_state_type st_q;
  ifsb_word_state_type st_d;

  // A hardware set in the same cycle as a software clear wins.
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.flags = wr_data;
    end
    st_d.flags = (st_d.flags | hw_set) & IMPL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.flags <= `IFSB_FLAG_RST;
    end else if (pce) begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hw_set_wins: assert property (
    pce |=> ((flags & $past(hw_set & IMPL)) == $past(hw_set & IMPL)))
    else $error("hardware set lost");
  a_unimpl_zero: assert property (
    (flags & ~IMPL) == `IFSB_ZERO16)
    else $error("unimplemented flag bit set");
  a_sw_write_val: assert property (
    pce && wr_en && hw_set == `IFSB_ZERO16 |=> flags == $past(wr_data & IMPL))
    else $error("software write not stored");
  a_flag_sticky: assert property (
    pce && !wr_en |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a write");

endmodule : ifsb_flag_word

`default_nettype wire

// >>> ifsb_pkg.sv
// Types shared by the flag bank modules.
`include "ifsb_cfg.svh"

package ifsb_pkg;

  typedef logic [`IFSB_DW-1:0] ifsb_word_type;

  typedef struct packed {
    logic memory_op_done_flag;
    logic adc_done_flag;
    logic serial1_transmit_flag;
    logic serial1_receive_flag;
    logic capcomp2_timer_flag;
    logic capcomp1_timer_flag;
    logic capcomp4_event_flag;
    logic capcomp3_event_flag;
    logic timer_one_flag;
    logic capcomp2_event_flag;
    logic capcomp1_event_flag;
    logic ext_irq0_flag;
    logic serial2_transmit_flag;
    logic serial2_receive_flag;
    logic ext_irq2_flag;
    logic capcomp4_timer_flag;
    logic capcomp3_timer_flag;
    logic capcomp5_event_flag;
    logic ext_irq1_flag;
    logic pin_change_flag;
    logic comparator_flag;
    logic port1_bus_collision_flag;
    logic port1_serial_event_flag;
    logic capcomp5_timer_flag;
    logic calendar_clock_flag;
    logic port2_bus_collision_flag;
    logic port2_serial_event_flag;
  } ifsb_src_type;

  typedef enum logic [1:0] {
    IFSB_IDLE   = 2'b00,
    IFSB_ANSWER = 2'b01
  } ifsb_phase_type;

  typedef struct packed {
    ifsb_word_type flags;
  } ifsb_word_state_type;

  typedef struct packed {
    ifsb_phase_type                   phase;
    logic                             pready;
    logic                             pslverr;
    logic [`IFSB_PDW-1:0]             prdata;
    logic [`IFSB_NW-1:0][`IFSB_DW-1:0] ena;
    logic                             evt_stat;
    logic                             evt_mask;
    logic                             irq;
  } ifsb_state_type;

endpackage : ifsb_pkg

// >>> ifsb_src_model.sv
// Model of the peripheral sources that raise flag requests.
`timescale 1ns/1ps
`default_nettype none

module ifsb_src_model
  import ifsb_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire ifsb_src_type fire,
  input  wire ifsb_src_type hold,
  output var  ifsb_src_type src_req
);
  ifsb_src_type pulse_q;

  // Each fired source raises its request one cycle later, for as many cycles as it is fired.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= fire;
    end
  end

  // Held sources keep requesting, as a busy peripheral would.
  always_comb begin
    src_req = pulse_q | hold;
  end
endmodule : ifsb_src_model

`default_nettype wire

// >>> ifsb_top.sv
// APB flag status bank with per-flag enables and one interrupt line.
`timescale 1ns/1ps
`default_nettype none

module ifsb_top
  import ifsb_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 pce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`IFSB_PAW-1:0] paddr,
  input  wire logic [`IFSB_PDW-1:0] pwdata,
  input  wire logic [3:0]           pstrb,
  input  wire ifsb_src_type         src_req,
  output var  logic [`IFSB_PDW-1:0] prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  output var  logic                 irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [`IFSB_NW-1:0][`IFSB_DW-1:0] IMPL = {
    `IFSB_IMPL3, `IFSB_IMPL2, `IFSB_IMPL1, `IFSB_IMPL0
  };

  ifsb_state_type                    st_q;
  ifsb_state_type                    st_d;
  logic [`IFSB_NW-1:0][`IFSB_DW-1:0] flags_all;
  logic [`IFSB_NW-1:0][`IFSB_DW-1:0] set_v;
  logic [`IFSB_NW-1:0][`IFSB_DW-1:0] wdat_v;
  logic [`IFSB_NW-1:0]               wr_v;
  logic [`IFSB_NW-1:0]               sel_flag;
  logic [`IFSB_NW-1:0]               sel_ena;
  logic                              sel_evt;
  logic                              sel_emsk;
  logic                              mapped;
  logic [`IFSB_DW-1:0]               rd_word;
  logic [`IFSB_DW-1:0]               lane_mask;
  logic                              fire;
  logic                              wr_fire;
  logic                              pend;

  // ----------------------------------------------------------------------
  // Request routing
  // ----------------------------------------------------------------------
  // A source held high sets its flag every cycle, so a software
  // clear cannot win until the source lets go.
  always_comb begin
    set_v = '0;
    set_v[0][`IFSB_B0_MEMOP] = src_req.memory_op_done_flag;
    set_v[0][`IFSB_B0_ADC]   = src_req.adc_done_flag;
    set_v[0][`IFSB_B0_S1TX]  = src_req.serial1_transmit_flag;
    set_v[0][`IFSB_B0_S1RX]  = src_req.serial1_receive_flag;
    set_v[0][`IFSB_B0_CC2T]  = src_req.capcomp2_timer_flag;
    set_v[0][`IFSB_B0_CC1T]  = src_req.capcomp1_timer_flag;
    set_v[0][`IFSB_B0_CC4E]  = src_req.capcomp4_event_flag;
    set_v[0][`IFSB_B0_CC3E]  = src_req.capcomp3_event_flag;
    set_v[0][`IFSB_B0_TMR1]  = src_req.timer_one_flag;
    set_v[0][`IFSB_B0_CC2E]  = src_req.capcomp2_event_flag;
    set_v[0][`IFSB_B0_CC1E]  = src_req.capcomp1_event_flag;
    set_v[0][`IFSB_B0_EXT0]  = src_req.ext_irq0_flag;
    set_v[1][`IFSB_B1_S2TX]  = src_req.serial2_transmit_flag;
    set_v[1][`IFSB_B1_S2RX]  = src_req.serial2_receive_flag;
    set_v[1][`IFSB_B1_EXT2]  = src_req.ext_irq2_flag;
    set_v[1][`IFSB_B1_CC4T]  = src_req.capcomp4_timer_flag;
    set_v[1][`IFSB_B1_CC3T]  = src_req.capcomp3_timer_flag;
    set_v[1][`IFSB_B1_CC5E]  = src_req.capcomp5_event_flag;
    set_v[1][`IFSB_B1_EXT1]  = src_req.ext_irq1_flag;
    set_v[1][`IFSB_B1_PCHG]  = src_req.pin_change_flag;
    set_v[1][`IFSB_B1_CMP]   = src_req.comparator_flag;
    set_v[1][`IFSB_B1_P1BC]  = src_req.port1_bus_collision_flag;
    set_v[1][`IFSB_B1_P1EV]  = src_req.port1_serial_event_flag;
    set_v[2][`IFSB_B2_CC5T]  = src_req.capcomp5_timer_flag;
    set_v[3][`IFSB_B3_CAL]   = src_req.calendar_clock_flag;
    set_v[3][`IFSB_B3_P2BC]  = src_req.port2_bus_collision_flag;
    set_v[3][`IFSB_B3_P2EV]  = src_req.port2_serial_event_flag;
  end

  // ----------------------------------------------------------------------
  // Address decode and read data
  // ----------------------------------------------------------------------
  // Read data is captured in the setup cycle, so a flag set during
  // the access phase shows on the next read.
  always_comb begin
    sel_flag = '0;
    sel_ena  = '0;
    sel_evt  = 1'b0;
    sel_emsk = 1'b0;
    rd_word  = `IFSB_ZERO16;
    case (paddr)
      `IFSB_OFF_FLAG0: begin
        sel_flag[0] = 1'b1;
        rd_word     = flags_all[0];
      end
      `IFSB_OFF_FLAG1: begin
        sel_flag[1] = 1'b1;
        rd_word     = flags_all[1];
      end
      `IFSB_OFF_FLAG2: begin
        sel_flag[2] = 1'b1;
        rd_word     = flags_all[2];
      end
      `IFSB_OFF_FLAG3: begin
        sel_flag[3] = 1'b1;
        rd_word     = flags_all[3];
      end
      `IFSB_OFF_ENA0: begin
        sel_ena[0] = 1'b1;
        rd_word    = st_q.ena[0];
      end
      `IFSB_OFF_ENA1: begin
        sel_ena[1] = 1'b1;
        rd_word    = st_q.ena[1];
      end
      `IFSB_OFF_ENA2: begin
        sel_ena[2] = 1'b1;
        rd_word    = st_q.ena[2];
      end
      `IFSB_OFF_ENA3: begin
        sel_ena[3] = 1'b1;
        rd_word    = st_q.ena[3];
      end
      `IFSB_OFF_EVT: begin
        sel_evt = 1'b1;
        rd_word[`IFSB_EVT_BIT] = st_q.evt_stat;
      end
      `IFSB_OFF_EMSK: begin
        sel_emsk = 1'b1;
        rd_word[`IFSB_EVT_BIT] = st_q.evt_mask;
      end
      default: begin
        rd_word = `IFSB_ZERO16;
      end
    endcase
    mapped = (|sel_flag) | (|sel_ena) | sel_evt | sel_emsk;
  end

  // Only byte lanes 0 and 1 carry register bits.
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign fire      = (st_q.phase == IFSB_ANSWER) && psel && penable;
  assign wr_fire   = fire && pwrite && mapped;
  assign pend      = |(flags_all & st_q.ena);

  // ----------------------------------------------------------------------
  // Flag words
  // ----------------------------------------------------------------------
  for (genvar gi = 0; gi < `IFSB_NW; gi++) begin : g_word
    assign wr_v[gi]   = wr_fire && sel_flag[gi];
    assign wdat_v[gi] = (flags_all[gi] & ~lane_mask)
                      | (pwdata[`IFSB_DW-1:0] & lane_mask);

    ifsb_flag_word #(
      .IMPL (IMPL[gi])
    ) u_word (
      .pclk    (pclk),
      .presetn (presetn),
      .pce     (pce),
      .hw_set  (set_v[gi]),
      .wr_en   (wr_v[gi]),
      .wr_data (wdat_v[gi]),
      .flags   (flags_all[gi])
    );
  end

  // ----------------------------------------------------------------------
  // Bus slave, enables and interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q.phase)
      IFSB_IDLE: begin
        if (psel && !penable) begin
          st_d.phase   = IFSB_ANSWER;
          st_d.pready  = 1'b1;
          st_d.pslverr = !mapped;
          st_d.prdata  = {{(`IFSB_PDW-`IFSB_DW){1'b0}}, rd_word};
        end
      end
      IFSB_ANSWER: begin
        if (psel && penable) begin
          st_d.phase   = IFSB_IDLE;
          st_d.pready  = 1'b0;
          st_d.pslverr = 1'b0;
        end
      end
    endcase
    if (wr_fire) begin
      for (int i = 0; i < `IFSB_NW; i++) begin
        if (sel_ena[i]) begin
          st_d.ena[i] = ((st_q.ena[i] & ~lane_mask)
                      | (pwdata[`IFSB_DW-1:0] & lane_mask)) & IMPL[i];
        end
      end
      if (sel_emsk && pstrb[0]) begin
        st_d.evt_mask = pwdata[`IFSB_EVT_BIT];
      end
      if (sel_evt && pstrb[0] && pwdata[`IFSB_EVT_BIT]) begin
        st_d.evt_stat = 1'b0;
      end
    end
    // An unmapped access sets the event after any clear, so it wins.
    if (fire && !mapped) begin
      st_d.evt_stat = 1'b1;
    end
    st_d.irq = pend | (st_q.evt_stat & st_q.evt_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (pce) begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.prdata;
  assign pready  = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign irq     = st_q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    pce && psel && !penable && st_q.phase == IFSB_IDLE;
  endsequence

  sequence s_answer;
    pready && psel && penable;
  endsequence

  a_reset_clear: assert property (
    $rose(presetn) |-> flags_all == '0 && !irq && !pready)
    else $error("state not clear after reset");
  a_word0_high: assert property (
    pce && src_req.adc_done_flag |=> flags_all[0][`IFSB_B0_ADC])
    else $error("converter flag not set");
  a_word0_low: assert property (
    pce && src_req.timer_one_flag |=> flags_all[0][`IFSB_B0_TMR1])
    else $error("timer flag not set");
  a_word1_high: assert property (
    pce && src_req.ext_irq2_flag |=> flags_all[1][`IFSB_B1_EXT2])
    else $error("external 2 flag not set");
  a_word1_low: assert property (
    pce && src_req.pin_change_flag |=> flags_all[1][`IFSB_B1_PCHG])
    else $error("pin change flag not set");
  a_word2_only: assert property (
    pce && src_req.capcomp5_timer_flag |=>
      flags_all[2][`IFSB_B2_CC5T] && (flags_all[2] & ~`IFSB_IMPL2) == '0)
    else $error("word2 layout wrong");
  a_word3_cal: assert property (
    pce && src_req.calendar_clock_flag |=> flags_all[3][`IFSB_B3_CAL])
    else $error("calendar flag not set");
  // The layout checks pick a few sources per byte; the bench walks
  // every source through its own bit.
  a_word0_memop: assert property (
    pce && src_req.memory_op_done_flag |=> flags_all[0][`IFSB_B0_MEMOP])
    else $error("memory flag not set");
  a_word0_serial: assert property (
    pce && src_req.serial1_receive_flag |=> flags_all[0][`IFSB_B0_S1RX])
    else $error("serial 1 receive flag not set");
  a_word0_ext0: assert property (
    pce && src_req.ext_irq0_flag |=> flags_all[0][`IFSB_B0_EXT0])
    else $error("external 0 flag not set");
  a_word1_serial2: assert property (
    pce && src_req.serial2_transmit_flag |=> flags_all[1][`IFSB_B1_S2TX])
    else $error("serial 2 transmit flag not set");
  a_word1_ext1: assert property (
    pce && src_req.ext_irq1_flag |=> flags_all[1][`IFSB_B1_EXT1])
    else $error("external 1 flag not set");
  a_word1_collide: assert property (
    pce && src_req.port1_bus_collision_flag |=> flags_all[1][`IFSB_B1_P1BC])
    else $error("port 1 collision flag not set");
  a_word3_port2: assert property (
    pce && src_req.port2_serial_event_flag |=> flags_all[3][`IFSB_B3_P2EV])
    else $error("port 2 event flag not set");
  a_word3_collide: assert property (
    pce && src_req.port2_bus_collision_flag |=> flags_all[3][`IFSB_B3_P2BC])
    else $error("port 2 collision flag not set");
  a_irq_forward: assert property (
    pce |=> irq == $past(pend | (st_q.evt_stat & st_q.evt_mask)))
    else $error("interrupt does not follow enabled flags");
  a_irq_quiet: assert property (
    pce && st_q.ena == '0 && !st_q.evt_mask |=> !irq)
    else $error("interrupt raised with nothing enabled");
  a_irq_enabled: assert property (
    pce && |(flags_all[0] & st_q.ena[0]) |=> irq)
    else $error("enabled flag did not raise interrupt");
  a_evt_irq: assert property (
    pce && st_q.evt_stat && st_q.evt_mask |=> irq)
    else $error("unmasked event did not raise interrupt");
  a_ena_impl: assert property (
    (st_q.ena[0] & ~`IFSB_IMPL0) == '0 && (st_q.ena[1] & ~`IFSB_IMPL1) == '0
    && (st_q.ena[2] & ~`IFSB_IMPL2) == '0
    && (st_q.ena[3] & ~`IFSB_IMPL3) == '0)
    else $error("enable bit outside layout");

  // ----------------------------------------------------------------------
  // Bus protocol and clock-enable assertions
  // ----------------------------------------------------------------------

  a_read_word: assert property (
    s_setup ##1 (pce and s_answer) |->
      prdata == {{(`IFSB_PDW-`IFSB_DW){1'b0}}, $past(rd_word)})
    else $error("read data wrong");
  a_read_upper: assert property (
    pready |-> prdata[`IFSB_PDW-1:`IFSB_DW] == '0)
    else $error("upper read bits not zero");
  a_apb_answer: assert property (
    s_setup |=> pready)
    else $error("slave answer timing wrong");
  a_apb_release: assert property (
    (pce and s_answer) |=> !pready)
    else $error("ready held past completion");
  a_err_event: assert property (
    ((pce && pslverr) and s_answer) |=> st_q.evt_stat)
    else $error("unmapped access did not raise event");
  a_pce_freeze: assert property (
    !pce |=> $stable(flags_all) && $stable(st_q))
    else $error("state moved while clock enable low");

endmodule : ifsb_top

`default_nettype wire

// >>> ifsb_top_bench.sv
// Self-checking bench for the flag status bank.
`timescale 1ns/1ps
`default_nettype none

module ifsb_top_bench
  import ifsb_pkg::*;
;
  logic         pclk;
  logic         presetn;
  logic         pce;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  ifsb_src_type src_req;
  ifsb_src_type fire;
  ifsb_src_type hold;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic [31:0]  rdata;
  logic         rerr;
  int           errors;
  int           samples_checked;
  int           k;
  localparam logic [15:0] IMPL [4] = '{16'hb9ef, 16'hf85f, 16'h0200,
                                       16'h4006};

  ifsb_top i_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .src_req(src_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  ifsb_src_model i_src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .hold(hold), .src_req(src_req));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000, 4'hf);
  endtask : rd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    fire = '0;
    hold = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(irq), 32'h0);
    for (int w = 0; w < 4; w++) begin
      rd(12'(4 * w));
      chk(rdata, 32'h0);
      chk(32'(rerr), 32'h0);
      wr(12'(4 * w), 32'hffff_ffff);
      rd(12'(4 * w));
      chk(rdata, {16'h0000, IMPL[w]});
      wr(12'(4 * w), 32'h0000_0000);
      rd(12'(4 * w));
      chk(rdata, 32'h0);
    end
    // Only the low byte lane is written.
    xfer(1'b1, 12'h000, 32'h0000_ffff, 4'b0001);
    rd(12'h000);
    chk(rdata, 32'h0000_00ef);
    wr(12'h000, 32'h0);
    // Every source lands on its own bit, with all enables off.
    k = 26;
    for (int w = 0; w < 4; w++) begin
      for (int b = 15; b >= 0; b--) begin
        if (IMPL[w][b]) begin
          fire <= ifsb_src_type'(27'd1 << k);
          @(posedge pclk);
          fire <= '0;
          rd(12'(4 * w));
          chk(rdata, 32'd1 << b);
          rd(12'(4 * w));
          chk(rdata, 32'd1 << b);
          chk(32'(irq), 32'h0);
          wr(12'(4 * w), 32'h0);
          rd(12'(4 * w));
          chk(rdata, 32'h0);
          k--;
        end
      end
    end
    // Enabled timer flag reaches the interrupt line.
    wr(12'h010, 32'h0000_0008);
    fire <= ifsb_src_type'(27'd1 << 18);
    @(posedge pclk);
    fire <= '0;
    repeat (4) @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(12'h010, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rd(12'h000);
    chk(rdata, 32'h0000_0008);
    wr(12'h000, 32'h0);
    // A held source beats a clearing write.
    hold <= ifsb_src_type'(27'd1 << 2);
    repeat (2) @(posedge pclk);
    wr(12'h00c, 32'h0);
    hold <= '0;
    rd(12'h00c);
    chk(rdata, 32'h0000_4000);
    wr(12'h00c, 32'h0);
    rd(12'h00c);
    chk(rdata, 32'h0);
    // Unmapped access raises the event, then mask and clear it.
    rd(12'h030);
    chk(32'(rerr), 32'h1);
    chk(rdata, 32'h0);
    rd(12'h020);
    chk(rdata, 32'h1);
    chk(32'(irq), 32'h0);
    wr(12'h024, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(12'h024, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(12'h024, 32'h1);
    wr(12'h020, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rd(12'h020);
    chk(rdata, 32'h0);
    // A frozen bank ignores a source pulse.
    pce  <= 1'b0;
    fire <= ifsb_src_type'(27'd1 << 26);
    @(posedge pclk);
    fire <= '0;
    repeat (3) @(posedge pclk);
    pce <= 1'b1;
    rd(12'h000);
    chk(rdata, 32'h0);
    // A second reset clears flags and the enables that drive the line.
    wr(12'h004, 32'hffff_ffff);
    wr(12'h014, 32'hffff_ffff);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004);
    chk(rdata, 32'h0);
    rd(12'h014);
    chk(rdata, 32'h0);
    chk(32'(irq), 32'h0);
    finish_test();
  end
endmodule : ifsb_top_bench

`default_nettype wire
